/* logic/sync_sep_timing.sv */
// Sync separator timing: line lock, sync pulses, field parity, register slave
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "sync_sep_defines.svh"
// Operation
// [R1] Horizontal pulse 12 ticks from tip fall
// [R2] Twice-line lockout drops half-line pulses
// [R3] Vertical low from serration to second rise
// [R4] Force vertical 31 us after equalizing
// [R5] Back porch 29 ticks from tip rise
// [R6] Back porch drives sample-and-hold switch
// [R7] Parity judged and updated at vertical start
// [R8] Parity high odd field, low even
// [R9] Lost flag low locked, high unlocked
// [R10] Lost forces sync outputs high except parity
// [R11] Composite sync is below-black part, slice select
// [R12] Pin-selected digital filter rejects short noise; here the filter bit of the CTRL register selects it
// [R13] Edges accepted only inside timing window; while lost_r is high any edge is accepted
// [R14] All widths scale with oscillator period; the glitch filter width counts core_clk cycles instead
// [R15] Slice select: half depth or fixed offset
// [R16] Filter removes short pulses, adds delay
// [R17] Free-running restore pulse without signal
// [R18] One tick domain, start out of lock
module sync_sep_timing #(
  parameter int FILT_CYC = `FILT_CYC
) (
  input wire logic core_clk, // 125 MHz clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [7:0] address, // Avalon byte address
  input wire logic read, // Avalon read
  input wire logic write, // Avalon write
  input wire logic [31:0] writedata, // Avalon write data
  output logic [31:0] readdata, // Avalon read data
  output logic waitrequest, // Avalon wait
  input wire logic sync_cmp_n, // comparator, low at sync tip
  output logic csync_n, // composite sync
  output logic hsync_n, // horizontal sync
  output logic vsync_n, // vertical sync
  output logic back_porch_n, // back porch pulse
  output logic field_odd, // field parity
  output logic sync_lost_flag, // high while out of lock
  output logic sample_hold, // restore loop sample switch
  output logic slice_sel, // comparator threshold select
  output logic irq // level interrupt
);
  initial begin
    if (FILT_CYC * `CLK_NS < `FILT_MIN_NS || FILT_CYC * `CLK_NS > `FILT_MAX_NS)
      $error("FILT_CYC outside the filter delay range");
  end

  sync_sep_pkg::bus_req_t req;
  assign req = '{rd: read, wr: write, addr: address, wdata: writedata};

  logic wait_r;
  logic [31:0] rdata_r;
  logic [1:0] ctrl_r;
  logic [15:0] div_r;
  logic [11:0] line_r;
  logic [2:0] istat_r;
  logic [2:0] mask_r;
  logic irq_r;
  wire logic bus_req = req.rd | req.wr;
  wire logic bus_acc = bus_req & ~wait_r;
  wire logic wr_acc = bus_acc & req.wr;
  wire logic stat_rd = bus_acc & req.rd & (req.addr == `REG_IRQ_STAT);

  // One wait cycle: data is latched while waitrequest is high, taken the edge after
  always_ff @(posedge core_clk) begin
    if (rst) wait_r <= 1'b1;
    else wait_r <= bus_acc | ~bus_req;
  end

  // Internal oscillator: one tick every div_r core cycles
  logic [15:0] div_cnt_r;
  wire logic tick = div_cnt_r == 16'h0000;
  always_ff @(posedge core_clk) begin
    if (rst) div_cnt_r <= 16'h0000;
    else div_cnt_r <= tick ? div_r - 16'h0001 : div_cnt_r - 16'h0001; // R14
  end

  logic tip;
  glitch_filter #(.LEN(FILT_CYC)) u_filt (
    .clk(core_clk),
    .rst(rst),
    .en(ctrl_r[`CTRL_FILTER]), // R12
    .d(~sync_cmp_n),
    .q(tip)
  );

  logic tip_d_r;
  wire logic tip_start = tip & ~tip_d_r;
  wire logic tip_end = ~tip & tip_d_r;

  // Line counter, window and lock
  logic [11:0] lc_r;
  logic lost_r;
  logic [1:0] good_r;
  wire logic [11:0] half = line_r >> 1;
  wire logic in_win = lc_r >= line_r - `WIN_TICKS; // R13
  wire logic line_acc = tip_start & (in_win | lost_r); // R2
  // An edge on the last window tick still counts as a line, not a miss
  wire logic overrun = tick & ~line_acc & (lc_r >= line_r + `WIN_TICKS);
  wire logic half_edge = tip_start & (lc_r >= half - `WIN_TICKS) & (lc_r <= half + `WIN_TICKS);
  wire logic gain = line_acc & in_win & lost_r & (good_r == `LOCK_LINES);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tip_d_r <= 1'b0;
      lc_r <= 12'h000;
      lost_r <= 1'b1; // R18
      good_r <= 2'h0;
    end else begin
      tip_d_r <= tip;
      if (line_acc || overrun) lc_r <= 12'h000; // R17
      else if (tick && lc_r != 12'hFFF) lc_r <= lc_r + 12'h001;
      if (overrun) begin
        lost_r <= 1'b1; // R9
        good_r <= 2'h0;
      end else if (gain) begin
        lost_r <= 1'b0; // R9
      end else if (line_acc && lost_r) begin
        good_r <= in_win ? good_r + 2'h1 : 2'h0;
      end
    end
  end

  // Horizontal and back porch pulse counters, in ticks
  logic [11:0] h_cnt_r;
  logic [11:0] bp_cnt_r;
  logic bp_arm_r;
  wire logic hs_act = h_cnt_r != 12'h000;
  wire logic bp_act = bp_cnt_r != 12'h000;
  wire logic bp_start = (tip_end & bp_arm_r) | overrun;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      h_cnt_r <= 12'h000;
      bp_cnt_r <= 12'h000;
      bp_arm_r <= 1'b0;
    end else begin
      if (line_acc) h_cnt_r <= `HS_TICKS; // R1
      else if (tick && hs_act) h_cnt_r <= h_cnt_r - 12'h001;
      if (bp_start) bp_cnt_r <= `BP_TICKS; // R5
      else if (tick && bp_act) bp_cnt_r <= bp_cnt_r - 12'h001;
      if (line_acc) bp_arm_r <= 1'b1;
      else if (tip_end) bp_arm_r <= 1'b0;
    end
  end

  // Vertical: broad tip (quarter line) marks a serration; fallback after equalizing
  logic [11:0] tw_r;
  logic [11:0] gap_r;
  logic eq_seen_r;
  logic field_r;
  sync_sep_pkg::vstate_t vst_r;
  wire logic serr = tick & tip & (tw_r == (line_r >> 2));
  wire logic force_v = tick & eq_seen_r & (gap_r == `VDEF_TICKS);
  wire logic vs_start = (vst_r == sync_sep_pkg::V_IDLE) & ~lost_r & (serr | force_v);
  wire logic vs_act = vst_r != sync_sep_pkg::V_IDLE;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tw_r <= 12'h000;
      gap_r <= 12'h000;
      eq_seen_r <= 1'b0;
    end else begin
      if (tip_start) tw_r <= 12'h000;
      else if (tick && tip && tw_r != 12'hFFF) tw_r <= tw_r + 12'h001;
      if (tip_start) gap_r <= 12'h000;
      else if (tick && gap_r != 12'hFFF) gap_r <= gap_r + 12'h001;
      if (vs_start || lost_r) eq_seen_r <= 1'b0;
      else if (half_edge) eq_seen_r <= 1'b1; // R4
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      vst_r <= sync_sep_pkg::V_IDLE;
      field_r <= 1'b0;
    end else begin
      unique case (vst_r)
        sync_sep_pkg::V_IDLE: begin
          if (vs_start) vst_r <= sync_sep_pkg::V_ACTIVE; // R3 R4
        end
        sync_sep_pkg::V_ACTIVE: begin
          if (lost_r) vst_r <= sync_sep_pkg::V_IDLE;
          else if (tip_end) vst_r <= sync_sep_pkg::V_ONE_RISE;
        end
        sync_sep_pkg::V_ONE_RISE: begin
          if (lost_r || tip_end) vst_r <= sync_sep_pkg::V_IDLE; // R3
        end
        default: vst_r <= sync_sep_pkg::V_IDLE;
      endcase
      // Vertical edge in the first half of a line marks an odd field
      if (vs_start) field_r <= lc_r < half; // R7 R8
    end
  end

  // Events, mask and registers
  wire logic [2:0] events = {vs_start, overrun & ~lost_r, gain};
  wire logic [2:0] istat_nxt = (stat_rd ? 3'h0 : istat_r) | events;
  wire logic [11:0] wline = req.wdata[11:0];
  wire logic [15:0] wdiv = req.wdata[15:0];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_r <= `CTRL_RST;
      div_r <= `OSC_DIV_RST;
      line_r <= `LINE_RST;
      mask_r <= 3'h0;
      istat_r <= 3'h0;
    end else begin
      istat_r <= istat_nxt;
      if (wr_acc && req.addr == `REG_CTRL) ctrl_r <= req.wdata[1:0];
      if (wr_acc && req.addr == `REG_OSC_DIV) div_r <= (wdiv == 16'h0000) ? 16'h0001 : wdiv;
      if (wr_acc && req.addr == `REG_LINE) line_r <= (wline < 12'h040) ? 12'h040 : wline;
      if (wr_acc && req.addr == `REG_IRQ_MASK) mask_r <= req.wdata[2:0];
    end
  end

  logic [31:0] rd_mux;
  assign rd_mux = (req.addr == `REG_CTRL) ? {30'h0, ctrl_r} :
                  (req.addr == `REG_OSC_DIV) ? {16'h0, div_r} :
                  (req.addr == `REG_LINE) ? {20'h0, line_r} :
                  (req.addr == `REG_STATUS) ? {29'h0, vs_act, field_r, lost_r} :
                  // Latch the pending sets too, else an event just before the clear is lost
                  (req.addr == `REG_IRQ_STAT) ? {29'h0, istat_nxt} :
                  (req.addr == `REG_IRQ_MASK) ? {29'h0, mask_r} : 32'h0;

  // Output flops; a lost lock blanks every sync output so noise cannot chatter
  sync_sep_pkg::sync_out_t so_r;
  wire sync_sep_pkg::sync_out_t so_nxt = '{
    csync_n: lost_r | ~tip, // R10 R11
    hsync_n: lost_r | ~hs_act, // R10
    vsync_n: lost_r | ~vs_act, // R10
    bp_n: lost_r | ~bp_act}; // R10
  logic sh_r;
  logic field_out_r;
  logic slice_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      so_r <= '{csync_n: 1'b1, hsync_n: 1'b1, vsync_n: 1'b1, bp_n: 1'b1};
      sh_r <= 1'b0;
      field_out_r <= 1'b0;
      slice_r <= 1'b0;
      irq_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      so_r <= so_nxt;
      sh_r <= bp_act; // R6 R17
      field_out_r <= field_r;
      slice_r <= ctrl_r[`CTRL_SLICE]; // R15
      irq_r <= |(istat_r & mask_r);
      if (bus_req && wait_r) rdata_r <= req.rd ? rd_mux : 32'h0;
    end
  end

  assign csync_n = so_r.csync_n;
  assign hsync_n = so_r.hsync_n;
  assign vsync_n = so_r.vsync_n;
  assign back_porch_n = so_r.bp_n;
  assign field_odd = field_out_r;
  assign sync_lost_flag = lost_r;
  assign sample_hold = sh_r;
  assign slice_sel = slice_r;
  assign irq = irq_r;
  assign readdata = rdata_r;
  assign waitrequest = wait_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  lost_blanks_out_a: assert property (sync_lost_flag && $past(sync_lost_flag) |-> // R10
    hsync_n && vsync_n && back_porch_n && csync_n)
    else $error("sync output active while lock is lost");
  hsync_starts_a: assert property (line_acc && !lost_r |-> ##2 !hsync_n) // R1
    else $error("horizontal pulse did not start on an accepted edge");
  lockout_window_a: assert property ($rose(hs_act) && !$past(lost_r) |-> $past(in_win)) // R2
    else $error("horizontal pulse started outside the line window");
  porch_load_a: assert property ($rose(sample_hold) |-> $past(bp_cnt_r, 2) == 12'h000) // R5
    else $error("back porch pulse started without a fresh load");
  sample_follow_a: assert property (bp_start |-> ##2 sample_hold[*2]) // R6
    else $error("sample switch not driven by back porch");
  vsync_end_a: assert property (vst_r == sync_sep_pkg::V_ONE_RISE && tip_end |=> !vs_act) // R3
    else $error("vertical pulse not ended on second rising edge");
  vsync_force_a: assert property (force_v && !vs_act && !lost_r |=> vs_act ##1 !so_nxt.vsync_n) // R4
    else $error("default vertical pulse not forced");
  parity_update_a: assert property ($changed(field_odd) |-> $past(vs_start, 2)) // R7
    else $error("parity changed away from vertical start");
  lost_on_miss_a: assert property (overrun |=> sync_lost_flag) // R9
    else $error("missed line did not raise the lost flag");
  irq_level_a: assert property (|(istat_r & mask_r) |=> irq)
    else $error("interrupt low with unmasked status set");
endmodule
`default_nettype wire

/* logic/sync_sep_defines.svh */
// Offsets, field positions, reset values and timing counts of the sync separator
`ifndef SYNC_SEP_DEFINES_SVH
`define SYNC_SEP_DEFINES_SVH

`define CLK_NS 8
`define FILT_MIN_NS 150
`define FILT_MAX_NS 300
`define FILT_CYC ((`FILT_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define HS_TICKS 12'h00C
`define BP_TICKS 12'h01D
`define NOM_TICKS_PER_US 8
`define VDEF_US 31
`define VDEF_TICKS 12'(`VDEF_US * `NOM_TICKS_PER_US)
`define WIN_TICKS 12'h010
`define LOCK_LINES 2'h3

`define REG_CTRL 8'h00
`define REG_OSC_DIV 8'h04
`define REG_LINE 8'h08
`define REG_STATUS 8'h0C
`define REG_IRQ_STAT 8'h10
`define REG_IRQ_MASK 8'h14

`define CTRL_FILTER 0
`define CTRL_SLICE 1
`define EV_LOCK 0
`define EV_LOST 1
`define EV_VSYNC 2

`define CTRL_RST 2'h0
`define OSC_DIV_RST 16'h0010
`define LINE_RST 12'h1FC

`endif

/* logic/sync_sep_pkg.sv */
// Types shared by the sync separator files
package sync_sep_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic csync_n;
    logic hsync_n;
    logic vsync_n;
    logic bp_n;
  } sync_out_t;

  typedef enum logic [1:0] {V_IDLE, V_ACTIVE, V_ONE_RISE} vstate_t;
endpackage

/* logic/glitch_filter.sv */
// Pulse rejection filter: passes a level only after it held for LEN cycles
`timescale 1ns/1ns
`default_nettype none
module glitch_filter #(
  parameter int LEN = 19
) (
  input wire logic clk, // core clock
  input wire logic rst, // synchronous reset
  input wire logic en, // filter on
  input wire logic d, // raw level
  output logic q // filtered level
);
  initial begin
    if (LEN < 1 || LEN > 255) $error("glitch_filter LEN out of range");
  end

  logic [7:0] cnt_r;
  logic q_r;
  wire logic differs = d != q_r;
  // Compare against LEN, not LEN-1, so the delay is LEN whole cycles
  wire logic full = cnt_r == 8'(LEN);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 8'h00;
      q_r <= 1'b0;
    end else if (!en) begin
      cnt_r <= 8'h00;
      q_r <= d;
    end else if (!differs) begin
      cnt_r <= 8'h00;
    end else if (full) begin
      cnt_r <= 8'h00;
      q_r <= d; // R16
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  assign q = q_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  filt_reject_a: assert property ($changed(q_r) && $past(en) |-> $past(d) == q_r) // R16
    else $error("filtered level changed to a value the input did not hold");
endmodule
`default_nettype wire

/* test/video_src_model.sv */
// Composite video sync source as seen through the slicer comparator
`timescale 1ns/1ns
`default_nettype none
module video_src_model (
  input wire logic core_clk, // bench clock
  input wire logic [1:0] mode, // 0 no signal, 1 lines, 2 half-line, 3 broad
  input wire logic glitch, // short extra pulse mid-line
  input wire logic [7:0] tip_len, // tip width in cycles
  input wire logic [8:0] line_len, // line period in cycles
  output logic sync_cmp_n // low at sync tip
);
  logic [8:0] cnt_r;
  wire logic [8:0] half = line_len >> 1;
  wire logic [8:0] pos = (cnt_r >= half) ? cnt_r - half : cnt_r;
  wire logic mid = glitch && cnt_r >= half && cnt_r < half + 9'h006;
  initial begin
    cnt_r = 9'h000;
    sync_cmp_n = 1'b1;
  end
  always @(posedge core_clk) begin
    cnt_r <= (cnt_r >= line_len - 9'h001) ? 9'h000 : cnt_r + 9'h001;
    case (mode)
      2'h1: sync_cmp_n <= !(cnt_r < 9'(tip_len) || mid);
      2'h2: sync_cmp_n <= !(pos < 9'(tip_len));
      // Broad pulses long enough to start the vertical interval
      2'h3: sync_cmp_n <= !(pos < half - 9'h00A);
      default: sync_cmp_n <= 1'b1;
    endcase
  end
endmodule
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench of the sync separator timing block
`timescale 1ns/1ns
`default_nettype none
`include "sync_sep_defines.svh"
module tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, q;
  logic waitrequest, sync_cmp_n, csync_n, hsync_n, vsync_n, back_porch_n;
  logic field_odd, sync_lost_flag, sample_hold, slice_sel, irq;
  logic glitch = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [7:0] tip_len = 8'h18;
  logic [8:0] line_len = 9'h080;
  logic exp_odd = 1'b0;
  logic [15:0] seed = 16'h3854;
  int err_count = 0, n_compared = 0, cyc = 0, hs_cnt = 0, cs_cnt = 0, v_cnt = 0, sh_cnt = 0;
  int t_in, t_hs, t_bp, hs_w, bp_w, lat_cs, lat_hs, lat0, h0, c0, v0, bad;
  always #4 core_clk = ~core_clk;
  sync_sep_timing #(.FILT_CYC(19)) u_dut (.core_clk(core_clk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .sync_cmp_n(sync_cmp_n), .csync_n(csync_n), .hsync_n(hsync_n),
    .vsync_n(vsync_n), .back_porch_n(back_porch_n), .field_odd(field_odd),
    .sync_lost_flag(sync_lost_flag), .sample_hold(sample_hold), .slice_sel(slice_sel), .irq(irq));
  video_src_model u_src (.core_clk(core_clk), .mode(mode), .glitch(glitch), .tip_len(tip_len),
    .line_len(line_len), .sync_cmp_n(sync_cmp_n));
  always @(negedge sync_cmp_n) t_in = int'($time);
  always @(negedge csync_n) begin
    lat_cs = (int'($time) - t_in) / 8;
    cs_cnt++;
  end
  always @(negedge hsync_n) begin
    t_hs = int'($time);
    lat_hs = (t_hs - t_in) / 8;
    hs_cnt++;
  end
  always @(posedge hsync_n) hs_w = (int'($time) - t_hs) / 8;
  always @(negedge back_porch_n) t_bp = int'($time);
  always @(posedge back_porch_n) bp_w = (int'($time) - t_bp) / 8;
  always @(negedge vsync_n) v_cnt++;
  // Parity by rule: a vertical falling in the first half of a source line is odd
  always @(negedge vsync_n) exp_odd = u_src.cnt_r < (line_len >> 1);
  always @(posedge sample_hold) sh_cnt++;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Holds the request until waitrequest is sampled low, then releases it
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    @(posedge core_clk);
    while (waitrequest !== 1'b0) @(posedge core_clk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(n, q, exp);
  endtask
  task automatic wait_lost(input logic v);
    int k;
    for (k = 0; k < 3000 && sync_lost_flag !== v; k++) @(posedge core_clk);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    // Ceiling about twice the ten thousand cycles the sequence needs
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk("lost_at_start", sync_lost_flag, 1);
    chk("outs_at_start", {csync_n, hsync_n, vsync_n, back_porch_n}, 4'hF);
    rd_chk("ctrl_rst", `REG_CTRL, 32'h0);
    rd_chk("div_rst", `REG_OSC_DIV, 32'h10);
    rd_chk("line_rst", `REG_LINE, 32'h1FC);
    rd_chk("mask_rst", `REG_IRQ_MASK, 32'h0);
    rd_chk("unmapped", 8'h20, 32'h0);
    bus(1'b1, `REG_OSC_DIV, 32'h0);
    rd_chk("div_floor", `REG_OSC_DIV, 32'h1);
    bus(1'b1, `REG_LINE, 32'h10);
    rd_chk("line_floor", `REG_LINE, 32'h40);
    bus(1'b1, `REG_LINE, 32'h80);
    bus(1'b1, `REG_CTRL, 32'h2);
    repeat (2) @(posedge core_clk);
    chk("slice_hi", slice_sel, 1);
    bus(1'b1, `REG_CTRL, 32'h0);
    repeat (2) @(posedge core_clk);
    chk("slice_lo", slice_sel, 0);
    sh_cnt = 0;
    repeat (960) @(posedge core_clk);
    chk("free_run", sh_cnt >= 2, 1);
    seed = lfsr(seed);
    bus(1'b1, `REG_IRQ_MASK, {29'h0, seed[2:0]});
    rd_chk("mask_rw", `REG_IRQ_MASK, {29'h0, seed[2:0]});
    bus(1'b1, `REG_IRQ_MASK, 32'h1);
    bus(1'b0, `REG_IRQ_STAT, 32'h0);
    tip_len <= 8'h14 + {5'h00, seed[5:3]};
    mode <= 2'h1;
    wait_lost(1'b0);
    chk("locked", sync_lost_flag, 0);
    @(posedge core_clk);
    chk("irq_lock", irq, 1);
    rd_chk("stat_lock", `REG_IRQ_STAT, 32'h1);
    repeat (2) @(posedge core_clk);
    chk("irq_clr", irq, 0);
    repeat (256) @(posedge core_clk);
    lat0 = lat_cs;
    chk("hs_after_cs", lat_hs - lat_cs, 1);
    chk("hs_width", hs_w >= 11 && hs_w <= 13, 1);
    chk("bp_width", bp_w >= 28 && bp_w <= 30, 1);
    bad = 0;
    repeat (128) begin
      @(posedge core_clk);
      bad += int'(sample_hold !== !back_porch_n);
    end
    chk("sh_is_bp", bad, 0);
    glitch <= 1'b1;
    repeat (128) @(posedge core_clk);
    h0 = hs_cnt;
    c0 = cs_cnt;
    repeat (512) @(posedge core_clk);
    chk("cs_glitch", cs_cnt - c0, 8);
    chk("hs_window", hs_cnt - h0, 4);
    bus(1'b1, `REG_CTRL, 32'h1);
    // The filter delay moves edges out of the window at this short line; wait for relock
    repeat (1024) @(posedge core_clk);
    c0 = cs_cnt;
    repeat (512) @(posedge core_clk);
    chk("cs_filtered", cs_cnt - c0, 4);
    chk("filt_delay", lat_cs - lat0, 19);
    glitch <= 1'b0;
    bus(1'b1, `REG_CTRL, 32'h0);
    // Half-line pulses cannot bring lock back, so relock on plain lines first
    repeat (1024) @(posedge core_clk);
    mode <= 2'h2;
    repeat (256) @(posedge core_clk);
    h0 = hs_cnt;
    repeat (512) @(posedge core_clk);
    chk("half_line", hs_cnt - h0, 4);
    v0 = v_cnt;
    mode <= 2'h3;
    repeat (384) @(posedge core_clk);
    mode <= 2'h1;
    repeat (256) @(posedge core_clk);
    chk("vs_seen", v_cnt - v0 >= 1, 1);
    chk("vs_end", vsync_n, 1);
    bus(1'b0, `REG_IRQ_STAT, 32'h0);
    chk("vs_event", q[2], 1);
    rd_chk("field_bit", `REG_STATUS, {29'h0, 1'b0, exp_odd, 1'b0});
    chk("field_out", field_odd, exp_odd);
    bus(1'b1, `REG_IRQ_MASK, 32'h0);
    // Longer line so the default vertical delay ends before the miss
    line_len <= 9'h100;
    bus(1'b1, `REG_LINE, 32'h100);
    repeat (1536) @(posedge core_clk);
    mode <= 2'h2;
    repeat (512) @(posedge core_clk);
    while (u_src.cnt_r != 9'h010) @(posedge core_clk);
    v0 = v_cnt;
    mode <= 2'h0;
    wait_lost(1'b1);
    chk("vs_forced", v_cnt - v0, 1);
    chk("field_even", field_odd, exp_odd);
    chk("lost", sync_lost_flag, 1);
    repeat (2) @(posedge core_clk);
    chk("blanked", {csync_n, hsync_n, vsync_n, back_porch_n}, 4'hF);
    bus(1'b0, `REG_IRQ_STAT, 32'h0);
    chk("lost_event", q[1], 1);
    chk("irq_masked", irq, 0);
    end_sim();
  end
endmodule
`default_nettype wire
